// File: rtl/ccs_clock_select.sv
// Clock select control: sub oscillator mode, subclock select, cpu clock enable
`timescale 1ns/100ps
module ccs_clock_select #(
    parameter int PERIPH_STAGES = ccs_pkg::PERIPH_DIV_STAGES
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [15:0] cpu_addr,
    input wire logic cpu_wr,
    input wire logic [7:0] cpu_wdata,
    input wire logic cpu_bit_wr,
    input wire logic [2:0] cpu_bit_sel,
    input wire logic cpu_bit_val,
    input wire logic cpu_rd,
    output logic [7:0] cpu_rdata,
    input wire logic main_divide_select,
    input wire logic main_osc_stop,
    input wire logic sub_clk_pin,
    input wire logic halt_req,
    input wire logic stop_req,
    input wire logic wake,
    output logic cpu_clk_en,
    output logic main_osc_run,
    output logic sub_osc_run,
    output logic feedback_resistor_off,
    output logic cpu_on_sub_status,
    output logic halt_active,
    output logic stop_active,
    output logic stop_refused,
    output logic sub_periph_en,
    output logic [PERIPH_STAGES-1:0] main_periph_en
);
    // ------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------
    if (PERIPH_STAGES < ccs_pkg::MAIN_SLOW_DIV_LOG2 || PERIPH_STAGES > 16) begin : g_chk
        $error("ccs_clock_select: PERIPH_STAGES out of range");
    end

    // Byte after a write or bit write to the addressed register
    function automatic logic [7:0] wr_merge(input logic [7:0] cur, input logic bitw,
                                            input logic [2:0] sel, input logic val,
                                            input logic [7:0] wdata);
        logic [7:0] res;
        res = wdata;
        if (bitw) begin
            res = cur;
            res[sel] = val;
        end
        return res;
    endfunction

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    logic sub_osc_stop_r;
    logic feedback_off_r;
    logic cpu_source_select_r;
    logic any_wr;
    logic [7:0] mode_cur;
    logic [7:0] sel_cur;
    logic [7:0] mode_nxt;
    logic [7:0] sel_nxt;

    assign any_wr = cpu_wr || cpu_bit_wr;
    assign mode_cur = {6'h00, feedback_off_r, sub_osc_stop_r};
    assign sel_cur = {2'h0, cpu_on_sub_status, cpu_source_select_r, 4'h0};
    assign mode_nxt = wr_merge(mode_cur, cpu_bit_wr, cpu_bit_sel, cpu_bit_val, cpu_wdata);
    assign sel_nxt = wr_merge(sel_cur, cpu_bit_wr, cpu_bit_sel, cpu_bit_val, cpu_wdata);

    // Sub oscillator mode; upper bits are not stored, so stray ones read back zero
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sub_osc_stop_r <= ccs_pkg::SUB_OSC_MODE_RST[ccs_pkg::SUB_OSC_STOP_BIT];
            feedback_off_r <= ccs_pkg::SUB_OSC_MODE_RST[ccs_pkg::FEEDBACK_OFF_BIT];
        end else if (any_wr && cpu_addr == ccs_pkg::SUB_OSC_MODE_ADDR) begin
            sub_osc_stop_r <= mode_nxt[ccs_pkg::SUB_OSC_STOP_BIT];
            feedback_off_r <= mode_nxt[ccs_pkg::FEEDBACK_OFF_BIT];
        end
    end

    // Subclock select; status bit ignores writes
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cpu_source_select_r <= ccs_pkg::SUBCLK_SEL_RST[ccs_pkg::CPU_SRC_SEL_BIT];
        end else if (any_wr && cpu_addr == ccs_pkg::SUBCLK_SEL_ADDR) begin
            cpu_source_select_r <= sel_nxt[ccs_pkg::CPU_SRC_SEL_BIT];
        end
    end

    // Read data held in a flop; unmapped addresses read zero
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cpu_rdata <= 8'h00;
        end else if (cpu_rd) begin
            if (cpu_addr == ccs_pkg::SUB_OSC_MODE_ADDR) begin
                cpu_rdata <= mode_cur;
            end else if (cpu_addr == ccs_pkg::SUBCLK_SEL_ADDR) begin
                cpu_rdata <= sel_cur;
            end else begin
                cpu_rdata <= 8'h00;
            end
        end
    end

    assign feedback_resistor_off = feedback_off_r;
    assign sub_osc_run = !sub_osc_stop_r;

    // ------------------------------------------------------------
    // Main oscillator control
    // ------------------------------------------------------------
    logic main_released_r;
    logic main_stop_eff_r;
    logic stop_r;
    logic halt_r;

    // Oscillator held off under reset, released on the first edge after it
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            main_released_r <= 1'b0;
        end else begin
            main_released_r <= 1'b1;
        end
    end

    // Stop request only honoured while running from the sub clock
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            main_stop_eff_r <= ccs_pkg::MAIN_CLK_CTRL_RST[ccs_pkg::MAIN_OSC_STOP_BIT];
        end else if (cpu_on_sub_status) begin
            main_stop_eff_r <= main_osc_stop;
        end
    end

    assign main_osc_run = main_released_r && !main_stop_eff_r && !stop_r;
    // Main oscillator modelled as one tick per mclk while running
    logic main_tick;
    assign main_tick = main_osc_run;

    // ------------------------------------------------------------
    // Dividers
    // ------------------------------------------------------------
    logic [PERIPH_STAGES-1:0] main_div;

    ccs_divider #(
        .STAGES(PERIPH_STAGES)
    ) u_main_div (
        .mclk(mclk),
        .rst_n(rst_n),
        .en(main_tick),
        .tick(main_div)
    );

    // Peripheral clocks vanish when the main oscillator stops
    assign main_periph_en = main_div;

    // ------------------------------------------------------------
    // Sub clock pin: synchroniser and edge detect
    // ------------------------------------------------------------
    logic sub_meta_r;
    logic sub_sync_r;
    logic sub_last_r;
    logic sub_tick;
    logic sub_half_r;
    logic sub_div2_tick;

    // Pin crosses through two flops before use
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sub_meta_r <= 1'b0;
            sub_sync_r <= 1'b0;
            sub_last_r <= 1'b0;
        end else begin
            sub_meta_r <= sub_clk_pin;
            sub_sync_r <= sub_meta_r;
            sub_last_r <= sub_sync_r;
        end
    end

    assign sub_tick = sub_sync_r && !sub_last_r && sub_osc_run;

    // Halve the sub clock for the cpu
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sub_half_r <= 1'b0;
        end else if (sub_tick) begin
            sub_half_r <= !sub_half_r;
        end
    end

    assign sub_div2_tick = sub_tick && sub_half_r;
    // Timers, watch timer and display only; keeps running in standby
    assign sub_periph_en = sub_tick;

    // ------------------------------------------------------------
    // Cpu clock selection and switch-over
    // ------------------------------------------------------------
    logic applied_div_r;
    logic [1:0] old_count_r;
    logic switch_pending;
    logic raw_cpu_en;

    assign switch_pending = (cpu_source_select_r != cpu_on_sub_status) ||
        (!cpu_source_select_r && main_divide_select != applied_div_r);

    // Three choices: main, main/4, sub/2
    always_comb begin
        if (cpu_on_sub_status) begin
            raw_cpu_en = sub_div2_tick;
        end else if (applied_div_r) begin
            raw_cpu_en = main_div[ccs_pkg::MAIN_SLOW_DIV_LOG2-1];
        end else begin
            raw_cpu_en = main_tick;
        end
    end

    assign cpu_clk_en = raw_cpu_en && !halt_r && !stop_r;

    // Count old-clock cycles, then swap between two enables
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            old_count_r <= 2'd0;
        end else if (!switch_pending) begin
            old_count_r <= 2'd0;
        end else if (raw_cpu_en) begin
            if (old_count_r == 2'(ccs_pkg::SWITCH_OLD_CLOCKS - 1)) begin
                old_count_r <= 2'd0;
            end else begin
                old_count_r <= old_count_r + 2'd1;
            end
        end
    end

    // Applied selection; status changes only at the swap point
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cpu_on_sub_status <= ccs_pkg::SUBCLK_SEL_RST[ccs_pkg::CPU_ON_SUB_BIT];
            applied_div_r <= ccs_pkg::MAIN_CLK_CTRL_RST[ccs_pkg::MAIN_DIV_SEL_BIT];
        end else if (switch_pending && raw_cpu_en &&
                     old_count_r == 2'(ccs_pkg::SWITCH_OLD_CLOCKS - 1)) begin
            cpu_on_sub_status <= cpu_source_select_r;
            applied_div_r <= main_divide_select;
        end
    end

    // ------------------------------------------------------------
    // Standby modes
    // ------------------------------------------------------------
    // Halt allowed on either source
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            halt_r <= 1'b0;
        end else if (wake) begin
            halt_r <= 1'b0;
        end else if (halt_req) begin
            halt_r <= 1'b1;
        end
    end

    // Stop refused while on the sub clock, since main cannot be restarted from it
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            stop_r <= 1'b0;
            stop_refused <= 1'b0;
        end else begin
            stop_refused <= stop_req && cpu_on_sub_status;
            if (wake) begin
                stop_r <= 1'b0;
            end else if (stop_req && !cpu_on_sub_status) begin
                stop_r <= 1'b1;
            end
        end
    end

    assign halt_active = halt_r;
    assign stop_active = stop_r;
endmodule

// File: rtl/ccs_pkg.sv
// Package: constants for the clock select control block
package ccs_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [15:0] SUB_OSC_MODE_ADDR = 16'hFFF0;
    localparam logic [15:0] SUBCLK_SEL_ADDR = 16'hFFF2;
    localparam logic [7:0] SUB_OSC_MODE_RST = 8'h00;
    localparam logic [7:0] SUBCLK_SEL_RST = 8'h00;
    localparam logic [7:0] MAIN_CLK_CTRL_RST = 8'h02;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int SUB_OSC_STOP_BIT = 0;
    localparam int FEEDBACK_OFF_BIT = 1;
    localparam int CPU_SRC_SEL_BIT = 4;
    localparam int CPU_ON_SUB_BIT = 5;
    localparam int MAIN_DIV_SEL_BIT = 1;
    localparam int MAIN_OSC_STOP_BIT = 7;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int SWITCH_OLD_CLOCKS = 2;
    localparam int MAIN_SLOW_DIV_LOG2 = 2;
    localparam int PERIPH_DIV_STAGES = 8;
endpackage

// File: rtl/ccs_divider.sv
// Ripple-free binary divider producing one-cycle enable pulses
`timescale 1ns/100ps
module ccs_divider #(
    parameter int STAGES = 8
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic en,
    output logic [STAGES-1:0] tick
);
    // ------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------
    if (STAGES < 1 || STAGES > 16) begin : g_chk
        $error("ccs_divider: STAGES must be 1..16");
    end

    logic [STAGES-1:0] count_r;
    logic [STAGES-1:0] all_ones;
    logic ones_run;

    // Prefix and of the count; a running and avoids variable-width part selects
    always_comb begin
        ones_run = 1'b1;
        for (int i = 0; i < STAGES; i++) begin
            ones_run = ones_run && count_r[i];
            all_ones[i] = ones_run;
        end
    end

    // Counter advances only on the source enable
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            count_r <= '0;
        end else if (en) begin
            count_r <= count_r + 1'b1;
        end
    end

    // Stage i pulses once every 2^(i+1) source enables
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            tick <= '0;
        end else begin
            tick <= {STAGES{en}} & all_ones;
        end
    end
endmodule

// File: tb/ccs_clock_select_assertions.sv
// Concurrent checks on the clock select control ports
`timescale 1ns/100ps
module ccs_sva (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [15:0] cpu_addr,
    input wire logic cpu_wr,
    input wire logic [7:0] cpu_wdata,
    input wire logic cpu_bit_wr,
    input wire logic cpu_rd,
    input wire logic [7:0] cpu_rdata,
    input wire logic main_osc_stop,
    input wire logic halt_req,
    input wire logic stop_req,
    input wire logic wake,
    input wire logic cpu_clk_en,
    input wire logic main_osc_run,
    input wire logic sub_osc_run,
    input wire logic feedback_resistor_off,
    input wire logic cpu_on_sub_status,
    input wire logic halt_active,
    input wire logic stop_active,
    input wire logic stop_refused
);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    property p_mode_wr;
        cpu_wr && cpu_addr == 16'hFFF0 |=>
            sub_osc_run == !$past(cpu_wdata[0]) && feedback_resistor_off == $past(cpu_wdata[1]);
    endproperty
    a_mode_wr: assert property (p_mode_wr) else $error("mode write not applied");
    property p_mode_rd;
        cpu_rd && cpu_addr == 16'hFFF0 && !cpu_wr && !cpu_bit_wr |=>
            cpu_rdata == {6'h00, $past(feedback_resistor_off), !$past(sub_osc_run)};
    endproperty
    a_mode_rd: assert property (p_mode_rd) else $error("mode read value wrong");
    property p_sel_rd;
        cpu_rd && cpu_addr == 16'hFFF2 |=>
            cpu_rdata[7:6] == 2'h0 && cpu_rdata[3:0] == 4'h0 &&
            cpu_rdata[5] == $past(cpu_on_sub_status);
    endproperty
    a_sel_rd: assert property (p_sel_rd) else $error("select read value wrong");
    // No disable here: the check is about the reset level itself
    property p_osc_rst;
        disable iff (1'b0) !rst_n |-> !main_osc_run && !cpu_clk_en;
    endproperty
    a_osc_rst: assert property (p_osc_rst) else $error("main osc runs in reset");
    property p_stop_ref;
        stop_req && cpu_on_sub_status && !wake |=> stop_refused && !stop_active;
    endproperty
    a_stop_ref: assert property (p_stop_ref) else $error("stop not refused on sub");
    property p_stop_main;
        stop_req && !cpu_on_sub_status && !wake |=> stop_active && !main_osc_run;
    endproperty
    a_stop_main: assert property (p_stop_main) else $error("stop not entered");
    property p_halt;
        halt_req && !wake && !stop_req |=> halt_active;
    endproperty
    a_halt: assert property (p_halt) else $error("halt not entered");
    property p_gate;
        halt_active || stop_active |-> !cpu_clk_en;
    endproperty
    a_gate: assert property (p_gate) else $error("cpu tick in standby");
    // Status may only move right after an old-source tick
    property p_status;
        $changed(cpu_on_sub_status) |-> $past(cpu_clk_en);
    endproperty
    a_status: assert property (p_status) else $error("status moved off tick");
    property p_mcc;
        (cpu_on_sub_status && main_osc_stop)[*2] |-> !main_osc_run;
    endproperty
    a_mcc: assert property (p_mcc) else $error("main osc not stopped");
    c_refused: cover property (stop_refused);
    c_to_sub: cover property ($rose(cpu_on_sub_status));
    c_halt: cover property ($rose(halt_active));
endmodule
bind ccs_clock_select ccs_sva ccs_sva_i (.mclk, .rst_n, .cpu_addr, .cpu_wr, .cpu_wdata,
    .cpu_bit_wr, .cpu_rd, .cpu_rdata, .main_osc_stop, .halt_req, .stop_req, .wake,
    .cpu_clk_en, .main_osc_run, .sub_osc_run, .feedback_resistor_off, .cpu_on_sub_status,
    .halt_active, .stop_active, .stop_refused);

// File: tb/tb_ccs_clock_select.sv
// Self-checking bench for the clock select control block
`timescale 1ns/100ps
module tb_ccs_clock_select;
    logic mclk, rst_n, cpu_wr, cpu_bit_wr, cpu_bit_val, cpu_rd, sub_clk_pin;
    logic [15:0] cpu_addr;
    logic [7:0] cpu_wdata, cpu_rdata, main_periph_en;
    logic [2:0] cpu_bit_sel;
    logic main_divide_select, main_osc_stop, halt_req, stop_req, wake, cpu_clk_en;
    logic main_osc_run, sub_osc_run, feedback_resistor_off, cpu_on_sub_status;
    logic halt_active, stop_active, stop_refused, sub_periph_en;
    int mismatches = 0;
    int cmp_count = 0;
    int n_cpu, n_sub, n_p0;
    ccs_clock_select #(.PERIPH_STAGES(8)) ccs_clock_select_i (.mclk, .rst_n, .cpu_addr,
        .cpu_wr, .cpu_wdata, .cpu_bit_wr, .cpu_bit_sel, .cpu_bit_val, .cpu_rd, .cpu_rdata,
        .main_divide_select, .main_osc_stop, .sub_clk_pin, .halt_req, .stop_req, .wake,
        .cpu_clk_en, .main_osc_run, .sub_osc_run, .feedback_resistor_off, .cpu_on_sub_status,
        .halt_active, .stop_active, .stop_refused, .sub_periph_en, .main_periph_en);
    // ------------------------------------------------------------
    // Clocks and bus tasks
    // ------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    // Sub clock period of 88 ns, exactly eleven mclk periods
    initial begin
        sub_clk_pin = 1'b0;
        // Offset keeps pin edges off the mclk edges, so sampling never races
        #1;
        forever #44 sub_clk_pin = ~sub_clk_pin;
    end
    task automatic end_sim();
        if (mismatches == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge mclk);
        cpu_addr <= a;
        cpu_wdata <= d;
        cpu_wr <= 1'b1;
        @(posedge mclk);
        cpu_wr <= 1'b0;
    endtask
    task automatic bw(input logic [15:0] a, input logic [2:0] s, input logic v);
        @(posedge mclk);
        cpu_addr <= a;
        cpu_bit_sel <= s;
        cpu_bit_val <= v;
        cpu_bit_wr <= 1'b1;
        @(posedge mclk);
        cpu_bit_wr <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] exp, input string what);
        @(posedge mclk);
        cpu_addr <= a;
        cpu_rd <= 1'b1;
        @(posedge mclk);
        cpu_rd <= 1'b0;
        #1;
        chk(what, exp, cpu_rdata);
    endtask
    // Kind 0 halt, 1 stop, 2 wake; returns just after the taking edge
    task automatic req(input int k);
        @(posedge mclk);
        halt_req <= (k == 0);
        stop_req <= (k == 1);
        wake <= (k == 2);
        @(posedge mclk);
        halt_req <= 1'b0;
        stop_req <= 1'b0;
        wake <= 1'b0;
        #1;
    endtask
    task automatic count(input int n);
        n_cpu = 0;
        n_sub = 0;
        n_p0 = 0;
        repeat (n) begin
            @(posedge mclk);
            #1;
            n_cpu += (cpu_clk_en === 1'b1);
            n_sub += (sub_periph_en === 1'b1);
            n_p0 += (main_periph_en[0] === 1'b1);
        end
    endtask
    // Bounded wait for the applied source to settle
    task automatic wait_sub(input logic v);
        for (int i = 0; i < 600; i++) begin
            if (cpu_on_sub_status === v) return;
            @(posedge mclk);
            #1;
        end
        mismatches++;
        $display("CHECK FAILED wait_sub expected %b seen %b", v, cpu_on_sub_status);
        end_sim();
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {rst_n, cpu_wr, cpu_bit_wr, cpu_bit_val, cpu_rd, halt_req, stop_req, wake} = 8'h00;
        {cpu_addr, cpu_wdata, cpu_bit_sel, main_osc_stop} = 28'h0000000;
        main_divide_select = 1'b1;
        repeat (2) @(posedge mclk);
        chk("osc_in_reset", 8'h00, {7'h00, main_osc_run});
        rst_n <= 1'b1;
        repeat (2) @(posedge mclk);
        rd(16'hFFF0, 8'h00, "mode_rst");
        rd(16'hFFF2, 8'h00, "sel_rst");
        count(40);
        chk("slow_main", 8'h0A, 8'(n_cpu));
        wr(16'hFFF0, 8'h03);
        rd(16'hFFF0, 8'h03, "mode_ff");
        chk("sub_run", 8'h00, {7'h00, sub_osc_run});
        chk("fb_off", 8'h01, {7'h00, feedback_resistor_off});
        bw(16'hFFF0, 3'h0, 1'b0);
        rd(16'hFFF0, 8'h02, "mode_bit");
        wr(16'hFFF0, 8'h00);
        main_divide_select <= 1'b0;
        count(20);
        count(40);
        chk("fast_main", 8'h28, 8'(n_cpu));
        chk("periph_half", 8'h14, 8'(n_p0));
        wr(16'hFFF2, 8'h10);
        wait_sub(1'b1);
        rd(16'hFFF2, 8'h30, "sel_sub");
        count(400);
        chk("sub_div2", 8'h01, {7'h00, n_sub > 30 && n_cpu * 2 >= n_sub - 2 &&
            n_cpu * 2 <= n_sub + 2});
        req(1);
        chk("stop_refused", 8'h02, {6'h00, stop_refused, stop_active});
        req(0);
        chk("halt_sub", 8'h01, {7'h00, halt_active});
        req(2);
        @(posedge mclk);
        main_osc_stop <= 1'b1;
        repeat (10) @(posedge mclk);
        count(40);
        chk("main_off", 8'h00, {7'h00, main_osc_run});
        chk("periph_stop", 8'h00, 8'(n_p0));
        chk("sub_alive", 8'h01, {7'h00, n_sub > 0});
        @(posedge mclk);
        main_osc_stop <= 1'b0;
        repeat (4) @(posedge mclk);
        wr(16'hFFF2, 8'h00);
        wait_sub(1'b0);
        rd(16'hFFF2, 8'h00, "sel_main");
        @(posedge mclk);
        main_osc_stop <= 1'b1;
        count(20);
        chk("stop_bit_ignored", 8'h01, {7'h00, main_osc_run});
        @(posedge mclk);
        main_osc_stop <= 1'b0;
        req(1);
        chk("stop_main", 8'h02, {6'h00, stop_active, main_osc_run});
        req(2);
        chk("woken", 8'h01, {6'h00, stop_active, main_osc_run});
        req(0);
        count(8);
        chk("halt_gates", 8'h00, 8'(n_cpu));
        req(2);
        wr(16'hFFF0, 8'h02);
        @(posedge mclk);
        rst_n <= 1'b0;
        @(posedge mclk);
        #1;
        chk("rst_again", 8'h00, {6'h00, feedback_resistor_off, main_osc_run});
        @(posedge mclk);
        rst_n <= 1'b1;
        repeat (2) @(posedge mclk);
        rd(16'hFFF0, 8'h00, "mode_rst2");
        end_sim();
    end
endmodule
